/* File: verilog/apc_adc_map.svh */
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   Definitions only
`ifndef APC_ADC_MAP_SVH
`define APC_ADC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define APC_OFF_CTRL 8'h00
`define APC_OFF_CFG 8'h04
`define APC_OFF_CMPCTL 8'h08
`define APC_OFF_RES_HI 8'h0c
`define APC_OFF_RES_LO 8'h10
`define APC_OFF_CV_HI 8'h14
`define APC_OFF_CV_LO 8'h18
`define APC_OFF_PIN_LO 8'h1c
`define APC_OFF_PIN_MID 8'h20
`define APC_OFF_PIN_HI 8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define APC_CTRL_CHAN_LSB 0
`define APC_CTRL_IEN_BIT 6
`define APC_CTRL_DONE_BIT 7
`define APC_CFG_CLK_LSB 0
`define APC_CFG_MODE_LSB 2
`define APC_CFG_DIV_LSB 5
`define APC_CMP_GE_BIT 4
`define APC_CMP_EN_BIT 5

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define APC_CHAN_OFF 5'h1f
`define APC_CFG_RST 6'h00
`define APC_PIN_RST 8'h00
`define APC_MODE_10BIT 2'h2
`define APC_RESP_OKAY 2'h0
`define APC_RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define APC_CLK_PERIOD_NS 10
`define APC_ASYNC_PERIOD_NS 500
`define APC_SAMPLE_TICKS 4'h3

`endif

/* File: verilog/apc_pkg.sv */
// Purpose: Types shared by the converter control block
// Assumes: Constants live in apc_adc_map.svh
// Notes:   Packed structs carry grouped control fields
package apc_pkg;

  // Converter sequence states
  typedef enum logic [1:0] {
    APC_IDLE = 2'b00,
    APC_SAMPLE = 2'b01,
    APC_APPROX = 2'b10,
    APC_STORE = 2'b11
  } apc_state_t;

  // Configuration fields
  typedef struct packed {
    logic [1:0] div;
    logic [1:0] mode;
    logic [1:0] clkSel;
  } apc_cfg_t;

  // Compare control fields
  typedef struct packed {
    logic en;
    logic ge;
  } apc_cmp_t;

endpackage : apc_pkg

/* File: verilog/apc_clk_div.sv */
// Purpose: Converter clock source select and divider, as a tick stream
// Assumes: Alternate clock arrives unsynchronised from another domain
// Notes:   Internal oscillator modelled as a free-running count on clk
`timescale 1ns/10ps
`include "apc_adc_map.svh"

module apc_clk_div (
  input wire logic clk,
  input wire logic arst_n,
  input wire apc_pkg::apc_cfg_t cfg,
  input wire logic stopMode,
  input wire logic alternateClock,
  output logic convTick,
  output logic asyncOscOn
);
  import apc_pkg::*;

  localparam int ASYNC_CYC = `APC_ASYNC_PERIOD_NS / `APC_CLK_PERIOD_NS;

  logic altSync1_ff; // First stage, read only by second
  logic altSync2_ff;
  logic altPrev_ff;
  logic halfTog_ff; // Halved bus clock phase
  logic [5:0] oscCnt_ff; // Internal oscillator phase
  logic [2:0] divCnt_ff;
  logic srcTick;
  logic [2:0] divLast;

  // ****************************************************************
  // Source clocks
  // ****************************************************************
  // Alternate clock synchroniser and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      altSync1_ff <= 1'b0;
      altSync2_ff <= 1'b0;
      altPrev_ff <= 1'b0;
    end else begin
      altSync1_ff <= alternateClock;
      altSync2_ff <= altSync1_ff;
      altPrev_ff <= altSync2_ff;
    end
  end

  // Bus halving and oscillator count never stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halfTog_ff <= 1'b0;
      oscCnt_ff <= 6'h00;
    end else begin
      halfTog_ff <= ~halfTog_ff;
      oscCnt_ff <= (oscCnt_ff == 6'(ASYNC_CYC - 1)) ? 6'h00 : oscCnt_ff + 6'h01;
    end
  end

  // Source select; bus sources halt in stop, oscillator keeps going
  always_comb begin
    unique case (cfg.clkSel)
      2'b00: srcTick = ~stopMode;
      2'b01: srcTick = ~stopMode & halfTog_ff;
      2'b10: srcTick = altSync2_ff & ~altPrev_ff;
      2'b11: srcTick = (oscCnt_ff == 6'h00);
    endcase
  end

  assign asyncOscOn = (cfg.clkSel == 2'b11);

  // ****************************************************************
  // Divider 1, 2, 4, 8
  // ****************************************************************
  assign divLast = 3'((4'h1 << cfg.div) - 4'h1);

  // Terminal count gives one converter tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_ff <= 3'h0;
      convTick <= 1'b0;
    end else begin
      convTick <= 1'b0;
      if (srcTick) begin
        if (divCnt_ff >= divLast) begin
          divCnt_ff <= 3'h0;
          convTick <= 1'b1;
        end else begin
          divCnt_ff <= divCnt_ff + 3'h1;
        end
      end
    end
  end

endmodule : apc_clk_div

/* File: verilog/apc_adc_ctrl.sv */
// Purpose: Pin control, clocking and result handling around a SAR converter
// Assumes: AXI4-Lite slave on clk; comparator and pads are asynchronous
// Notes:   One conversion per start; see handover for register layout
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "apc_adc_map.svh"

module apc_adc_ctrl #(
  parameter int ADDR_W = 8,
  parameter int PINS = 24
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] portOutEn,
  input wire logic [PINS-1:0] portPullupEn,
  input wire logic [PINS-1:0] padIn,
  output logic [PINS-1:0] padOutEn,
  output logic [PINS-1:0] padPullupEn,
  output logic [PINS-1:0] portReadData,
  input wire logic stop3Mode,
  input wire logic alternateClock,
  input wire logic cmpAbove,
  output logic [10:0] dacCode,
  output logic sampleEnable,
  output logic converterPowerOn,
  output logic [4:0] channelSelect,
  output logic doneIrq
);
  import apc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [ADDR_W-1:0] awAddr_ff; // Held write address
  logic awHeld_ff;
  logic [7:0] wData_ff; // Only the low byte is stored anywhere
  logic wKeep_ff; // Low byte lane enabled
  logic wHeld_ff;
  logic doWrite; // Both halves present, response slot free
  logic doRead;
  logic [4:0] chan_ff; // Channel select field
  logic doneIrqEn_ff;
  logic doneFlag_ff;
  apc_cfg_t cfg_ff;
  apc_cmp_t cmp_ff;
  logic [1:0] cvHi_ff;
  logic [7:0] cvLo_ff;
  logic [1:0] resHi_ff;
  logic [7:0] resLo_ff;
  logic [7:0] pinSel_ff [3]; // Low, mid, high pin control
  logic [PINS-1:0] pinSel;
  logic [PINS-1:0] padSync1_ff; // First stage, read only by second
  logic [PINS-1:0] padSync2_ff;
  logic cmpSync1_ff; // First stage, read only by second
  logic cmpSync2_ff;
  apc_state_t state_ff;
  apc_state_t nxt_state;
  logic [10:0] sar_ff; // Trial and kept bits
  logic [3:0] bitIdx_ff;
  logic [3:0] sampleCnt_ff;
  logic convTick;
  logic wrCtrl;
  logic abortReq; // Config, compare control or compare value write invalidates a conversion
  logic startReq;
  logic mode10;
  logic [9:0] rounded;
  logic cmpPass;
  logic storeOk;

  // Address decoder shared by write and read paths
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == `APC_OFF_CTRL) || (a == `APC_OFF_CFG) || (a == `APC_OFF_CMPCTL) ||
             (a == `APC_OFF_RES_HI) || (a == `APC_OFF_RES_LO) || (a == `APC_OFF_CV_HI) ||
             (a == `APC_OFF_CV_LO) || (a == `APC_OFF_PIN_LO) || (a == `APC_OFF_PIN_MID) ||
             (a == `APC_OFF_PIN_HI);
  endfunction : mapped

  // Round raw SAR word to the mode width, saturating at full scale
  function automatic logic [9:0] roundRaw(input logic [10:0] raw, input logic m10);
    logic [11:0] s10;
    logic [9:0] s8;
    s10 = {1'b0, raw} + 12'h001;
    s8 = {1'b0, raw[10:2]} + 10'h001;
    if (m10) begin
      roundRaw = s10[11] ? 10'h3ff : s10[10:1];
    end else begin
      roundRaw = s8[9] ? 10'h0ff : {2'h0, s8[8:1]};
    end
  endfunction : roundRaw

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = ~awHeld_ff;
  assign s_axi_wready = ~wHeld_ff;
  assign doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;

  // Address and data taken in either order, response after both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= 8'h00;
      wKeep_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_ff) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_ff) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata[7:0];
        wKeep_ff <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_ff) ? `APC_RESP_OKAY : `APC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register write strobes, only with the low lane enabled
  assign wrCtrl = doWrite & wKeep_ff & (awAddr_ff == `APC_OFF_CTRL);
  assign abortReq = doWrite & wKeep_ff & ((awAddr_ff == `APC_OFF_CFG) ||
                    (awAddr_ff == `APC_OFF_CMPCTL) || (awAddr_ff == `APC_OFF_CV_HI) ||
                    (awAddr_ff == `APC_OFF_CV_LO));
  assign startReq = wrCtrl & (wData_ff[4:0] != `APC_CHAN_OFF);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Channel and interrupt enable; all-ones channel disables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_ff <= `APC_CHAN_OFF;
      doneIrqEn_ff <= 1'b0;
    end else if (wrCtrl) begin
      chan_ff <= wData_ff[`APC_CTRL_CHAN_LSB +: 5];
      doneIrqEn_ff <= wData_ff[`APC_CTRL_IEN_BIT];
    end
  end

  // Configuration; reset picks undivided bus clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= `APC_CFG_RST;
    end else if (doWrite && wKeep_ff && awAddr_ff == `APC_OFF_CFG) begin
      cfg_ff.clkSel <= wData_ff[`APC_CFG_CLK_LSB +: 2];
      cfg_ff.mode <= wData_ff[`APC_CFG_MODE_LSB +: 2];
      cfg_ff.div <= wData_ff[`APC_CFG_DIV_LSB +: 2];
    end
  end

  // Compare control and compare value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_ff <= 2'h0;
      cvHi_ff <= 2'h0;
      cvLo_ff <= 8'h00;
    end else if (doWrite && wKeep_ff) begin
      if (awAddr_ff == `APC_OFF_CMPCTL) begin
        cmp_ff.en <= wData_ff[`APC_CMP_EN_BIT];
        cmp_ff.ge <= wData_ff[`APC_CMP_GE_BIT];
      end
      if (awAddr_ff == `APC_OFF_CV_HI) begin
        cvHi_ff <= wData_ff[1:0];
      end
      if (awAddr_ff == `APC_OFF_CV_LO) begin
        cvLo_ff <= wData_ff;
      end
    end
  end

  // Pin control registers, one byte per group of eight channels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) begin
        pinSel_ff[i] <= `APC_PIN_RST;
      end
    end else if (doWrite && wKeep_ff) begin
      if (awAddr_ff == `APC_OFF_PIN_LO) pinSel_ff[0] <= wData_ff;
      if (awAddr_ff == `APC_OFF_PIN_MID) pinSel_ff[1] <= wData_ff;
      if (awAddr_ff == `APC_OFF_PIN_HI) pinSel_ff[2] <= wData_ff;
    end
  end

  // ****************************************************************
  // Pin gating
  // ****************************************************************
  assign pinSel = {pinSel_ff[2], pinSel_ff[1], pinSel_ff[0]};

  // Pad inputs come from outside the clock domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      padSync1_ff <= '0;
      padSync2_ff <= '0;
    end else begin
      padSync1_ff <= padIn;
      padSync2_ff <= padSync1_ff;
    end
  end

  // Each pin gated by its own control bit
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gPin
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          padOutEn[g] <= 1'b0;
          padPullupEn[g] <= 1'b0;
          portReadData[g] <= 1'b0;
        end else begin
          padOutEn[g] <= portOutEn[g] & ~pinSel[g];
          padPullupEn[g] <= portPullupEn[g] & ~pinSel[g];
          portReadData[g] <= padSync2_ff[g] & ~pinSel[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Converter clock
  // ****************************************************************
  apc_clk_div uClkDiv (
    .clk(clk),
    .arst_n(arst_n),
    .cfg(cfg_ff),
    .stopMode(stop3Mode),
    .alternateClock(alternateClock),
    .convTick(convTick),
    .asyncOscOn()
  );

  // ****************************************************************
  // Conversion sequence
  // ****************************************************************
  assign mode10 = (cfg_ff.mode == `APC_MODE_10BIT);
  assign rounded = roundRaw(sar_ff, mode10);

  // Compare against 10-bit value, or low byte only in 8-bit mode
  always_comb begin
    logic [9:0] cv;
    cv = mode10 ? {cvHi_ff, cvLo_ff} : {2'h0, cvLo_ff};
    cmpPass = ~cmp_ff.en | (cmp_ff.ge ? (rounded >= cv) : (rounded < cv));
  end

  assign storeOk = (state_ff == APC_STORE) & cmpPass;

  // Comparator output is analog-side, synchronise it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmpSync1_ff <= 1'b0;
      cmpSync2_ff <= 1'b0;
    end else begin
      cmpSync1_ff <= cmpAbove;
      cmpSync2_ff <= cmpSync1_ff;
    end
  end

  // Next state; aborts and disable return to idle
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      APC_IDLE: if (startReq) nxt_state = APC_SAMPLE;
      APC_SAMPLE: if (convTick && sampleCnt_ff == `APC_SAMPLE_TICKS) nxt_state = APC_APPROX;
      APC_APPROX: if (convTick && bitIdx_ff == (mode10 ? 4'h0 : 4'h2)) nxt_state = APC_STORE;
      APC_STORE: nxt_state = APC_IDLE;
    endcase
    if (abortReq || (wrCtrl && !startReq)) begin
      nxt_state = APC_IDLE;
    end else if (wrCtrl) begin
      nxt_state = APC_SAMPLE;
    end
  end

  // State, sample count and successive approximation word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= APC_IDLE;
      sampleCnt_ff <= 4'h0;
      bitIdx_ff <= 4'ha;
      sar_ff <= 11'h000;
    end else begin
      state_ff <= nxt_state;
      if (startReq) begin
        sampleCnt_ff <= 4'h0;
        sar_ff <= 11'h000;
      end else if (state_ff == APC_SAMPLE && convTick) begin
        sampleCnt_ff <= sampleCnt_ff + 4'h1;
        if (nxt_state == APC_APPROX) begin
          bitIdx_ff <= 4'ha;
          sar_ff <= 11'h400; // First trial at the top bit
        end
      end else if (state_ff == APC_APPROX && convTick && nxt_state != APC_IDLE) begin
        sar_ff[bitIdx_ff] <= cmpSync2_ff;
        if (nxt_state == APC_APPROX) begin
          bitIdx_ff <= bitIdx_ff - 4'h1;
          sar_ff[bitIdx_ff - 4'h1] <= 1'b1;
        end
      end
    end
  end

  // Outputs to analog side; code and channel from flops, enables decoded from state_ff
  assign dacCode = sar_ff;
  assign sampleEnable = (state_ff == APC_SAMPLE);
  assign converterPowerOn = (state_ff != APC_IDLE);
  assign channelSelect = chan_ff;

  // ****************************************************************
  // Results and done flag
  // ****************************************************************
  // Results only move when the compare condition holds
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resHi_ff <= 2'h0;
      resLo_ff <= 8'h00;
    end else if (storeOk) begin
      resHi_ff <= mode10 ? rounded[9:8] : 2'h0;
      resLo_ff <= rounded[7:0];
    end
  end

  assign doRead = s_axi_arvalid & ~s_axi_rvalid;

  // Set wins over control write or low result read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      doneFlag_ff <= 1'b0;
    end else if (storeOk) begin
      doneFlag_ff <= 1'b1;
    end else if (wrCtrl || (doRead && s_axi_araddr == `APC_OFF_RES_LO)) begin
      doneFlag_ff <= 1'b0;
    end
  end

  assign doneIrq = doneFlag_ff & doneIrqEn_ff;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;

  // Registered read data, unmapped answers SLVERR with zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `APC_RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `APC_RESP_OKAY : `APC_RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        `APC_OFF_CTRL: s_axi_rdata[7:0] <= {doneFlag_ff, doneIrqEn_ff, 1'b0, chan_ff};
        `APC_OFF_CFG: s_axi_rdata[6:0] <= {cfg_ff.div, 1'b0, cfg_ff.mode, cfg_ff.clkSel};
        `APC_OFF_CMPCTL: s_axi_rdata[5:4] <= cmp_ff;
        `APC_OFF_RES_HI: s_axi_rdata[1:0] <= resHi_ff;
        `APC_OFF_RES_LO: s_axi_rdata[7:0] <= resLo_ff;
        `APC_OFF_CV_HI: s_axi_rdata[1:0] <= cvHi_ff;
        `APC_OFF_CV_LO: s_axi_rdata[7:0] <= cvLo_ff;
        `APC_OFF_PIN_LO: s_axi_rdata[7:0] <= pinSel_ff[0];
        `APC_OFF_PIN_MID: s_axi_rdata[7:0] <= pinSel_ff[1];
        `APC_OFF_PIN_HI: s_axi_rdata[7:0] <= pinSel_ff[2];
        default: s_axi_rdata <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : apc_adc_ctrl

/* File: bench/apc_pad_model.sv */
// Purpose: Pads, port logic and comparator beside the converter
// Assumes: Port logic asks for drive and pullup on every pin
// Notes: Comparator is ideal and noise free
`timescale 1ns/10ps
// ****************************************************************
// Pad and comparator model
// ****************************************************************
module apc_pad_model #(
  parameter int PINS = 24
) (
  input wire logic [10:0] dacCode,
  input wire logic [10:0] vin,
  output logic [PINS-1:0] portOutEn,
  output logic [PINS-1:0] portPullupEn,
  output logic [PINS-1:0] padIn,
  output logic cmpAbove
);
  // Port logic asks for everything, so any gating shows plainly
  assign portOutEn = '1;
  assign portPullupEn = '1;
  // Pads rest high on their pullups
  assign padIn = '1;
  // High when the input is at or above the trial code
  assign cmpAbove = (vin >= dacCode);
endmodule : apc_pad_model

/* File: bench/apc_adc_ctrl_chk.sv */
// Purpose: Port-level checks of the converter control block
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached to every instance by the bind at the foot
`timescale 1ns/10ps
// ****************************************************************
// Checker
// ****************************************************************
module apc_adc_ctrl_chk #(
  parameter int PINS = 24
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [PINS-1:0] portOutEn,
  input wire logic [PINS-1:0] portPullupEn,
  input wire logic [PINS-1:0] padOutEn,
  input wire logic [PINS-1:0] padPullupEn,
  input wire logic sampleEnable,
  input wire logic converterPowerOn,
  input wire logic [4:0] channelSelect,
  input wire logic doneIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Pins never gain drive or pullup that port logic did not ask for
  a_drive_gated: assert property ((padOutEn & ~$past(portOutEn)) == '0)
    else $error("pad drive without port request");
  a_pullup_gated: assert property ((padPullupEn & ~$past(portPullupEn)) == '0)
    else $error("pad pullup without port request");
  a_chan_off: assert property (channelSelect == 5'h1f && $past(channelSelect) == 5'h1f |-> !converterPowerOn)
    else $error("converter on with channel off");
  a_done_ends: assert property ($rose(doneIrq) |-> !converterPowerOn && $past(converterPowerOn))
    else $error("done without a finished conversion");
  a_sample_power: assert property (sampleEnable |-> converterPowerOn)
    else $error("sampling while powered down");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  // Main scenarios
  c_done: cover property ($rose(doneIrq));
  c_silent_end: cover property ($fell(converterPowerOn) ##1 !doneIrq);
  c_pins: cover property (padOutEn != portOutEn);
endmodule : apc_adc_ctrl_chk

bind apc_adc_ctrl apc_adc_ctrl_chk #(.PINS(PINS)) chk_u (.*);

/* File: bench/apc_adc_ctrl_tb.sv */
// Purpose: Self-checking bench for apc_adc_ctrl
// Assumes: 100 MHz clk, bench is the AXI4-Lite master
// Notes: Results follow from an ideal comparator
`timescale 1ns/10ps
`include "apc_adc_map.svh"
// ****************************************************************
// Bench
// ****************************************************************
module apc_adc_ctrl_tb;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] portOutEn, portPullupEn, padIn, padOutEn, padPullupEn, portReadData;
  logic stop3Mode, alternateClock, cmpAbove, sampleEnable, converterPowerOn, doneIrq;
  logic [10:0] dacCode, vin;
  logic [4:0] channelSelect;
  int mismatches, comparisons;
  // Per case: config, input level, rounded result, clocks per tick
  logic [7:0] cfgTab [6] = '{8'h69, 8'h40, 8'h0b, 8'h02, 8'h65, 8'h2d};
  logic [10:0] vinTab [6] = '{11'h2ab, 11'h7ff, 11'h7ff, 11'h155, 11'h004, 11'h400};
  logic [9:0] resTab [6] = '{10'h156, 10'h0ff, 10'h3ff, 10'h02b, 10'h001, 10'h080};
  int perTab [6] = '{16, 4, 50, 8, 16, 4};

  apc_adc_ctrl dut_u (.*);
  apc_pad_model #(.PINS(24)) pad_u (.*);

  // Bus clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Alternate source, off the bus clock phase
  initial begin
    alternateClock = 1'b0;
    #3;
    forever #40 alternateClock = ~alternateClock;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Bounds every wait; a hang counts as a mismatch
  task automatic bump(inout int n);
    n++;
    if (n > 3000) begin
      mismatches++;
      $display("Error wait expected answer seen timeout");
      end_sim();
    end
  endtask : bump

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ap, dp;
    n = 0;
    ap = 1'b1;
    dp = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (ap && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (dp && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        dp = 1'b0;
      end
      bump(n);
    end while (ap || dp || s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ap;
    n = 0;
    ap = 1'b1;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ap && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ap = 1'b0;
      end
      bump(n);
    end while (ap || s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("rdata", e, s_axi_rdata);
    cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  // Edges until the converter powers down
  task automatic waitIdle(output int n);
    n = 0;
    while (converterPowerOn !== 1'b0) begin
      @(posedge clk);
      bump(n);
    end
  endtask : waitIdle

  initial begin
    int n, nb;
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, stop3Mode, vin} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(`APC_OFF_PIN_LO, 32'h0, 2'h0);
    rd(`APC_OFF_PIN_HI, 32'h0, 2'h0);
    rd(`APC_OFF_CFG, 32'h0, 2'h0);
    rd(`APC_OFF_CTRL, 32'h1f, 2'h0);
    wr(`APC_OFF_PIN_LO, 8'h81, 2'h0);
    wr(`APC_OFF_PIN_MID, 8'h3c, 2'h0);
    wr(`APC_OFF_PIN_HI, 8'he7, 2'h0);
    @(posedge clk);
    #1;
    cmp("padOutEn", 32'h0018c37e, {8'h0, padOutEn});
    cmp("padPullupEn", 32'h0018c37e, {8'h0, padPullupEn});
    cmp("portReadData", 32'h0018c37e, {8'h0, portReadData});
    rd(`APC_OFF_PIN_MID, 32'h3c, 2'h0);
    wr(8'h40, 8'h55, `APC_RESP_SLVERR);
    rd(8'h40, 32'h0, `APC_RESP_SLVERR);
    wr(`APC_OFF_RES_LO, 8'h55, 2'h0);
    rd(`APC_OFF_RES_LO, 32'h0, 2'h0);
    // Every clock, divide and mode code at least once; tick slow enough for the comparator
    for (int i = 0; i < 6; i++) begin
      vin <= vinTab[i];
      nb = (cfgTab[i][3:2] == 2'h2) ? 11 : 9;
      wr(`APC_OFF_CFG, cfgTab[i], 2'h0);
      rd(`APC_OFF_CFG, {24'h0, cfgTab[i]}, 2'h0);
      stop3Mode <= (cfgTab[i][1:0] == 2'h3);
      wr(`APC_OFF_CTRL, 8'h43, 2'h0);
      waitIdle(n);
      cmp("convTime", 1, {31'h0, n >= perTab[i] * (nb + 3) && n <= perTab[i] * (nb + 6) + 8});
      @(posedge clk);
      #1;
      cmp("doneIrq", 1, {31'h0, doneIrq});
      rd(`APC_OFF_CTRL, 32'hc3, 2'h0);
      rd(`APC_OFF_RES_HI, {30'h0, resTab[i][9:8]}, 2'h0);
      rd(`APC_OFF_RES_LO, {24'h0, resTab[i][7:0]}, 2'h0);
      cmp("powerOn", 0, {31'h0, converterPowerOn});
    end
    // Compare: condition false keeps old result, then true takes the new one
    vin <= 11'h004;
    wr(`APC_OFF_CV_LO, 8'hff, 2'h0);
    wr(`APC_OFF_CMPCTL, 8'h30, 2'h0);
    wr(`APC_OFF_CFG, 8'h40, 2'h0);
    wr(`APC_OFF_CTRL, 8'h03, 2'h0);
    waitIdle(n);
    rd(`APC_OFF_CTRL, 32'h03, 2'h0);
    rd(`APC_OFF_RES_LO, 32'h80, 2'h0);
    wr(`APC_OFF_CMPCTL, 8'h20, 2'h0);
    wr(`APC_OFF_CTRL, 8'h03, 2'h0);
    waitIdle(n);
    rd(`APC_OFF_RES_LO, 32'h01, 2'h0);
    // Channel all ones stops a running conversion
    wr(`APC_OFF_CTRL, 8'h05, 2'h0);
    wr(`APC_OFF_CTRL, 8'h1f, 2'h0);
    #1;
    cmp("powerOn", 0, {31'h0, converterPowerOn});
    cmp("channelSelect", 32'h1f, {27'h0, channelSelect});
    end_sim();
  end
endmodule : apc_adc_ctrl_tb
